// ### gpc_pkg.sv
// Shared constants and types for the general pin configuration block
package gpc_pkg;

    // ==========================================================
    // APB register map (byte addresses)
    localparam logic [7:0] ADDR_LIVE_BASE = 8'h00;
    localparam logic [7:0] ADDR_NV_BASE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_EDGE_CFG = 8'h24;
    localparam int NUM_PINS = 4;

    // ==========================================================
    // Pin settings byte layout
    localparam int FLD_OUT_VAL = 4;
    localparam int FLD_DIR = 3;
    localparam int FLD_FUNC_LSB = 0;
    localparam int FLD_FUNC_W = 3;
    localparam logic [7:0] SETTINGS_RESET = 8'h08;
    localparam logic DIR_INPUT = 1'b1;

    // ==========================================================
    // Function codes
    localparam logic [2:0] FUNC_GPIO = 3'h0;
    localparam logic [2:0] P0_SUSPEND = 3'h1;
    localparam logic [2:0] P0_RX_LED = 3'h2;
    localparam logic [2:0] P1_CLK_OUT = 3'h1;
    localparam logic [2:0] P1_ANALOG_INPUT_1 = 3'h2;
    localparam logic [2:0] P1_TX_LED = 3'h3;
    localparam logic [2:0] P1_EDGE = 3'h4;
    localparam logic [2:0] P2_USB_CFG = 3'h1;
    localparam logic [2:0] P2_ANALOG_INPUT_2 = 3'h2;
    localparam logic [2:0] P2_ANALOG_OUTPUT_1 = 3'h3;
    localparam logic [2:0] P3_I2C_LED = 3'h1;
    localparam logic [2:0] P3_ANALOG_INPUT_3 = 3'h2;
    localparam logic [2:0] P3_ANALOG_OUTPUT_2 = 3'h3;

    // ==========================================================
    // Status and edge configuration fields
    localparam int ST_PIN_LSB = 0;
    localparam int ST_EDGE_FLAG = 4;
    localparam int ST_DETACHING = 5;
    localparam int EDGE_POS = 0;
    localparam int EDGE_NEG = 1;
    localparam logic [1:0] EDGE_CFG_RESET = 2'h0;

    // ==========================================================
    // Reset command report
    localparam int REPORT_LEN = 64;
    localparam logic [7:0] CMD_RESET_CHIP = 8'h70;
    localparam logic [7:0] KEY_BYTE_1 = 8'hab;
    localparam logic [7:0] KEY_BYTE_2 = 8'hcd;
    localparam logic [7:0] KEY_BYTE_3 = 8'hef;
    localparam logic [7:0] PAD_BYTE = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DETACH_NS = 10000;
    localparam int DETACH_CYC = (DETACH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {ST_RUN, ST_DETACH} gpc_restart_t;

endpackage : gpc_pkg

// ### gpc_pin_cell.sv
// One general pin: function select, GPIO direction and output value
`timescale 1ns/10ps
module gpc_pin_cell (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [7:0] i_settings,
    input wire logic [7:0] i_alt_out,
    input wire logic [7:0] i_alt_oe,
    input wire logic i_pin_in,
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_pin_sync
);

    logic [2:0] func;
    logic sync1_q;
    logic sync2_q;
    logic out_q;
    logic oe_q;

    assign func = i_settings[gpc_pkg::FLD_FUNC_LSB +: gpc_pkg::FLD_FUNC_W];

    // ==========================================================
    // Input synchroniser
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else if (i_ce)
        begin
            sync1_q <= i_pin_in;
            sync2_q <= sync1_q;
        end
    end

    // ==========================================================
    // Output driver; upper settings bits are not looked at
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end
        else if (i_ce)
        begin
            if (func == gpc_pkg::FUNC_GPIO)
            begin
                out_q <= i_settings[gpc_pkg::FLD_OUT_VAL];
                oe_q <= i_settings[gpc_pkg::FLD_DIR] != gpc_pkg::DIR_INPUT;
            end
            else
            begin
                out_q <= i_alt_out[func];
                oe_q <= i_alt_oe[func];
            end
        end
    end

    assign o_pin_out = out_q;
    assign o_pin_oe = oe_q;
    assign o_pin_sync = sync2_q;

    // ==========================================================
    // Checks
    a_gpio_out_drive: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && func == gpc_pkg::FUNC_GPIO && !i_settings[gpc_pkg::FLD_DIR])
        |=> (o_pin_oe && o_pin_out == $past(i_settings[gpc_pkg::FLD_OUT_VAL])))
        else $error("GPIO output not driven from value bit");
    a_gpio_in_release: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && func == gpc_pkg::FUNC_GPIO && i_settings[gpc_pkg::FLD_DIR]) |=> !o_pin_oe)
        else $error("GPIO input still driven");

endmodule : gpc_pin_cell

// ### gpc_reset_cmd.sv
// Detects the chip reset command in a stream of report bytes
`timescale 1ns/10ps
module gpc_reset_cmd (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    input wire logic i_last,
    input wire logic i_block,
    output logic o_reset_cmd,
    output logic o_rsp_req
);

    logic [5:0] idx_q;
    logic match_q;
    logic over_q;
    logic full_match;
    logic reset_q;
    logic rsp_q;

    // Expected content of a reset report at each byte position
    function automatic logic [7:0] expected_byte(input logic [5:0] idx);
        case (idx)
            6'h00: expected_byte = gpc_pkg::CMD_RESET_CHIP;
            6'h01: expected_byte = gpc_pkg::KEY_BYTE_1;
            6'h02: expected_byte = gpc_pkg::KEY_BYTE_2;
            6'h03: expected_byte = gpc_pkg::KEY_BYTE_3;
            default: expected_byte = gpc_pkg::PAD_BYTE;
        endcase
    endfunction : expected_byte

    // Every byte must match and the report must be exactly full length
    assign full_match = match_q && !over_q && (i_byte == expected_byte(idx_q))
        && (idx_q == 6'(gpc_pkg::REPORT_LEN - 1));

    // ==========================================================
    // Byte position and running comparison
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            idx_q <= 6'h00;
            match_q <= 1'b1;
            over_q <= 1'b0;
        end
        else if (i_ce && i_valid)
        begin
            if (i_last)
            begin
                idx_q <= 6'h00;
                match_q <= 1'b1;
                over_q <= 1'b0;
            end
            else
            begin
                match_q <= match_q && (i_byte == expected_byte(idx_q));
                if (idx_q == 6'(gpc_pkg::REPORT_LEN - 1))
                    over_q <= 1'b1;
                else
                    idx_q <= idx_q + 6'h01;
            end
        end
    end

    // ==========================================================
    // Outcome: reset, or a response for any other report; neither while i_block is high
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            reset_q <= 1'b0;
            rsp_q <= 1'b0;
        end
        else if (i_ce)
        begin
            reset_q <= i_valid && i_last && full_match && !i_block;
            rsp_q <= i_valid && i_last && !full_match && !i_block;
        end
    end

    assign o_reset_cmd = reset_q;
    assign o_rsp_req = rsp_q;

    // ==========================================================
    // Checks
    a_no_reset_reply: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_reset_cmd |-> !o_rsp_req)
        else $error("Response requested for reset command");
    a_pad_nonzero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && i_valid && i_last && i_byte != gpc_pkg::PAD_BYTE) |=> !o_reset_cmd)
        else $error("Reset taken with nonzero final byte");
    a_short_report: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && i_valid && i_last && idx_q != 6'h3f) |=> !o_reset_cmd)
        else $error("Reset taken from a short report");
    c_reset_seen: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_reset_cmd);

endmodule : gpc_reset_cmd

// ### gpc_top.sv
// General pin function configuration with chip reset command and APB registers
`timescale 1ns/10ps
module gpc_top (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_rpt_valid,
    input wire logic [7:0] i_rpt_byte,
    input wire logic i_rpt_last,
    output logic o_rsp_req,
    output logic o_usb_detach,
    input wire logic i_suspend_indicator,
    input wire logic i_usb_configured_flag,
    input wire logic i_rx_activity_led,
    input wire logic i_tx_activity_led,
    input wire logic i_i2c_activity_led,
    input wire logic i_clk_ref,
    input wire logic [3:0] i_general_pin_in,
    output logic [3:0] o_general_pin_out,
    output logic [3:0] o_general_pin_oe,
    output logic [2:0] o_analog_input_sel,
    output logic [1:0] o_analog_output_sel,
    output logic o_edge_event
);

    localparam int NP = gpc_pkg::NUM_PINS;

    logic [7:0] set_q [NP];
    logic [7:0] nv_q [NP];
    logic [7:0] alt_out [NP];
    logic [7:0] alt_oe [NP];
    logic [2:0] func [NP];
    logic [NP-1:0] pin_sync;
    logic [1:0] edge_cfg_q;
    logic edge_flag_q;
    logic edge_prev_q;
    logic edge_hit;
    logic edge_q;
    logic [2:0] ain_q;
    logic [1:0] aout_q;
    logic [31:0] prdata_q;
    logic cmd_reset;
    logic [9:0] det_cnt_q;
    gpc_pkg::gpc_restart_t state_q;
    logic wr_en;
    logic rd_setup;

    // ==========================================================
    // Address decode helpers
    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        in_bank = (a[7:4] == base[7:4]) && (a[1:0] == 2'h0);
    endfunction : in_bank

    function automatic logic mapped(input logic [7:0] a);
        mapped = in_bank(a, gpc_pkg::ADDR_LIVE_BASE) || in_bank(a, gpc_pkg::ADDR_NV_BASE)
            || (a == gpc_pkg::ADDR_STATUS) || (a == gpc_pkg::ADDR_EDGE_CFG);
    endfunction : mapped

    assign wr_en = i_psel && i_penable && i_pwrite && mapped(i_paddr);
    assign rd_setup = i_psel && !i_penable;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped(i_paddr);
    assign o_prdata = prdata_q;

    // ==========================================================
    // Live and stored pin settings
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < NP; i++)
            begin
                set_q[i] <= gpc_pkg::SETTINGS_RESET;
                nv_q[i] <= gpc_pkg::SETTINGS_RESET;
            end
        end
        else if (i_ce)
        begin
            if (cmd_reset && state_q == gpc_pkg::ST_RUN)
            begin
                for (int i = 0; i < NP; i++)
                    set_q[i] <= nv_q[i];
            end
            else if (wr_en && in_bank(i_paddr, gpc_pkg::ADDR_LIVE_BASE))
                set_q[i_paddr[3:2]] <= i_pwdata[7:0];
            if (wr_en && in_bank(i_paddr, gpc_pkg::ADDR_NV_BASE))
                nv_q[i_paddr[3:2]] <= i_pwdata[7:0];
        end
    end

    // ==========================================================
    // Edge detection configuration
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            edge_cfg_q <= gpc_pkg::EDGE_CFG_RESET;
        else if (i_ce && wr_en && i_paddr == gpc_pkg::ADDR_EDGE_CFG)
            edge_cfg_q <= i_pwdata[1:0];
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            prdata_q <= 32'h0000_0000;
        else if (i_ce && rd_setup)
        begin
            prdata_q <= 32'h0000_0000;
            if (in_bank(i_paddr, gpc_pkg::ADDR_LIVE_BASE))
                prdata_q[7:0] <= set_q[i_paddr[3:2]];
            else if (in_bank(i_paddr, gpc_pkg::ADDR_NV_BASE))
                prdata_q[7:0] <= nv_q[i_paddr[3:2]];
            else if (i_paddr == gpc_pkg::ADDR_STATUS)
            begin
                prdata_q[gpc_pkg::ST_PIN_LSB +: NP] <= pin_sync;
                prdata_q[gpc_pkg::ST_EDGE_FLAG] <= edge_flag_q;
                prdata_q[gpc_pkg::ST_DETACHING] <= state_q == gpc_pkg::ST_DETACH;
            end
            else if (i_paddr == gpc_pkg::ADDR_EDGE_CFG)
                prdata_q[1:0] <= edge_cfg_q;
        end
    end

    // ==========================================================
    // Function tables per pin; undefined codes release the pin
    always_comb
    begin
        for (int i = 0; i < NP; i++)
        begin
            alt_out[i] = 8'h00;
            alt_oe[i] = 8'h00;
            func[i] = set_q[i][gpc_pkg::FLD_FUNC_LSB +: gpc_pkg::FLD_FUNC_W];
        end
        alt_out[0][gpc_pkg::P0_SUSPEND] = i_suspend_indicator;
        alt_oe[0][gpc_pkg::P0_SUSPEND] = 1'b1;
        alt_out[0][gpc_pkg::P0_RX_LED] = i_rx_activity_led;
        alt_oe[0][gpc_pkg::P0_RX_LED] = 1'b1;
        alt_out[1][gpc_pkg::P1_CLK_OUT] = i_clk_ref;
        alt_oe[1][gpc_pkg::P1_CLK_OUT] = 1'b1;
        alt_out[1][gpc_pkg::P1_TX_LED] = i_tx_activity_led;
        alt_oe[1][gpc_pkg::P1_TX_LED] = 1'b1;
        alt_out[2][gpc_pkg::P2_USB_CFG] = i_usb_configured_flag;
        alt_oe[2][gpc_pkg::P2_USB_CFG] = 1'b1;
        alt_out[3][gpc_pkg::P3_I2C_LED] = i_i2c_activity_led;
        alt_oe[3][gpc_pkg::P3_I2C_LED] = 1'b1;
    end

    // ==========================================================
    // Pin cells
    for (genvar g = 0; g < NP; g++)
    begin : g_pin
        gpc_pin_cell u_cell (
            .i_mclk(i_mclk),
            .i_rstn(i_rstn),
            .i_ce(i_ce),
            .i_settings(set_q[g]),
            .i_alt_out(alt_out[g]),
            .i_alt_oe(alt_oe[g]),
            .i_pin_in(i_general_pin_in[g]),
            .o_pin_out(o_general_pin_out[g]),
            .o_pin_oe(o_general_pin_oe[g]),
            .o_pin_sync(pin_sync[g])
        );
    end

    // ==========================================================
    // Analog routing selects (pins released while analog)
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ain_q <= 3'h0;
            aout_q <= 2'h0;
        end
        else if (i_ce)
        begin
            ain_q <= {func[3] == gpc_pkg::P3_ANALOG_INPUT_3, func[2] == gpc_pkg::P2_ANALOG_INPUT_2,
                func[1] == gpc_pkg::P1_ANALOG_INPUT_1};
            aout_q <= {func[3] == gpc_pkg::P3_ANALOG_OUTPUT_2, func[2] == gpc_pkg::P2_ANALOG_OUTPUT_1};
        end
    end

    assign o_analog_input_sel = ain_q;
    assign o_analog_output_sel = aout_q;

    // ==========================================================
    // Edge detection on pin 1; flag set wins over clear
    assign edge_hit = (func[1] == gpc_pkg::P1_EDGE) &&
        ((edge_cfg_q[gpc_pkg::EDGE_POS] && pin_sync[1] && !edge_prev_q)
        || (edge_cfg_q[gpc_pkg::EDGE_NEG] && !pin_sync[1] && edge_prev_q));

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            edge_prev_q <= 1'b0;
            edge_q <= 1'b0;
            edge_flag_q <= 1'b0;
        end
        else if (i_ce)
        begin
            edge_prev_q <= pin_sync[1];
            edge_q <= edge_hit;
            if (edge_hit)
                edge_flag_q <= 1'b1;
            else if (wr_en && i_paddr == gpc_pkg::ADDR_STATUS
                && i_pwdata[gpc_pkg::ST_EDGE_FLAG])
                edge_flag_q <= 1'b0;
        end
    end

    assign o_edge_event = edge_q;

    // ==========================================================
    // Reset command detection
    gpc_reset_cmd u_cmd (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_valid(i_rpt_valid),
        .i_byte(i_rpt_byte),
        .i_last(i_rpt_last),
        .i_block(state_q == gpc_pkg::ST_DETACH),
        .o_reset_cmd(cmd_reset),
        .o_rsp_req(o_rsp_req)
    );

    // ==========================================================
    // Restart: detach from USB so the host enumerates again
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_q <= gpc_pkg::ST_RUN;
            det_cnt_q <= 10'h000;
        end
        else if (i_ce)
        begin
            case (state_q)
                gpc_pkg::ST_RUN:
                begin
                    if (cmd_reset)
                    begin
                        state_q <= gpc_pkg::ST_DETACH;
                        det_cnt_q <= 10'(gpc_pkg::DETACH_CYC - 1);
                    end
                end
                gpc_pkg::ST_DETACH:
                begin
                    if (det_cnt_q == 10'h000)
                        state_q <= gpc_pkg::ST_RUN;
                    else
                        det_cnt_q <= det_cnt_q - 10'h001;
                end
                default: state_q <= gpc_pkg::ST_RUN;
            endcase
        end
    end

    assign o_usb_detach = state_q == gpc_pkg::ST_DETACH;

    // ==========================================================
    // Checks
    a_restart_detach: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && cmd_reset && state_q == gpc_pkg::ST_RUN) |=> o_usb_detach[*8])
        else $error("Detach not held after reset command");
    a_reload_stored: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && cmd_reset && state_q == gpc_pkg::ST_RUN)
        |=> (set_q[0] == $past(nv_q[0]) && set_q[3] == $past(nv_q[3])))
        else $error("Stored settings not loaded on restart");
    a_p0_undef_free: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && func[0] > gpc_pkg::P0_RX_LED) |=> !o_general_pin_oe[0])
        else $error("Pin 0 driven with undefined code");
    a_p1_clock_out: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && func[1] == gpc_pkg::P1_CLK_OUT)
        |=> (o_general_pin_oe[1] && o_general_pin_out[1] == $past(i_clk_ref)))
        else $error("Clock not routed to pin 1");
    a_apb_unmapped: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_ce && $past(i_ce) && i_psel && i_penable && !mapped(i_paddr))
        |-> (o_pslverr && o_prdata == 32'h0000_0000))
        else $error("Unmapped access not flagged or read data not zero");
    c_detach_done: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        $fell(o_usb_detach));
    c_edge_seen: cover property (@(posedge i_mclk) disable iff (!i_rstn) o_edge_event);
    c_gpio_drive: cover property (@(posedge i_mclk) disable iff (!i_rstn)
        o_general_pin_oe[2] && func[2] == gpc_pkg::FUNC_GPIO);

endmodule : gpc_top

// ### gpc_host_model.sv
// Host side model that sends 64-byte command reports
`timescale 1ns/10ps
module gpc_host_model (
    input wire logic i_mclk,
    output logic o_valid,
    output logic [7:0] o_byte,
    output logic o_last
);
    initial
    begin
        o_valid = 1'b0;
        o_byte = 8'h5a;
        o_last = 1'b0;
    end

    // ==========================================================
    // Report sender
    function automatic logic [7:0] byte_at(input int i, input logic bad);
        case (i)
            0: byte_at = gpc_pkg::CMD_RESET_CHIP;
            1: byte_at = gpc_pkg::KEY_BYTE_1;
            2: byte_at = gpc_pkg::KEY_BYTE_2;
            3: byte_at = bad ? 8'h12 : gpc_pkg::KEY_BYTE_3;
            default: byte_at = gpc_pkg::PAD_BYTE;
        endcase
    endfunction : byte_at

    // Bytes go back to back; no response is awaited afterwards
    task send(input logic bad);
        for (int i = 0; i < gpc_pkg::REPORT_LEN; i++)
        begin
            o_valid <= 1'b1;
            o_last <= (i == gpc_pkg::REPORT_LEN - 1);
            o_byte <= byte_at(i, bad);
            @(posedge i_mclk);
        end
        o_valid <= 1'b0;
        o_last <= 1'b0;
        o_byte <= 8'hff;
    endtask : send
endmodule : gpc_host_model

// ### gpc_top_test.sv
// Self-checking testbench for the general pin configuration block
`timescale 1ns/10ps
module gpc_top_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] rd;
    logic prdy;
    logic perr;
    logic err;
    logic edge_ev;
    logic [5:0] src = 6'h3f;
    int n_edge = 0;
    logic rv;
    logic [7:0] rb;
    logic rl;
    logic rsp;
    logic det;
    logic [3:0] pout;
    logic [3:0] poe;
    logic [2:0] asel;
    logic [1:0] dsel;
    logic [3:0] pin_in = 4'h5;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_rsp = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    gpc_host_model u_host (.i_mclk(clk), .o_valid(rv), .o_byte(rb), .o_last(rl));

    gpc_top i_dut (.i_mclk(clk), .i_rstn(rstn), .i_ce(1'b1), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_rpt_valid(rv),
        .i_rpt_byte(rb), .i_rpt_last(rl), .o_rsp_req(rsp), .o_usb_detach(det),
        .i_suspend_indicator(src[0]), .i_usb_configured_flag(src[1]),
        .i_rx_activity_led(src[2]), .i_tx_activity_led(src[3]),
        .i_i2c_activity_led(src[4]), .i_clk_ref(src[5]), .i_general_pin_in(pin_in),
        .o_general_pin_out(pout), .o_general_pin_oe(poe),
        .o_analog_input_sel(asel), .o_analog_output_sel(dsel), .o_edge_event(edge_ev));

    // ==========================================================
    // Shared tasks
    task final_report();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cyc++;
        if (rsp === 1'b1)
            n_rsp++;
        if (edge_ev === 1'b1)
            n_edge++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        pen <= 1'b0;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb

    task set_pin(input int p, input logic [7:0] v);
        apb(1'b1, 8'(p * 4), {24'h0, v});
        repeat (2) @(posedge clk);
    endtask : set_pin

    // ==========================================================
    // Scenarios
    task t_regs();
        for (int p = 0; p < 8; p++)
        begin
            apb(1'b0, 8'(p * 4), 32'h0);
            chk("settings reset", 32'h8, rd);
        end
        apb(1'b0, gpc_pkg::ADDR_STATUS, 32'h0);
        chk("synced pins", 32'h5, rd & 32'hf);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        chk("pins released", 32'h0, {28'h0, poe});
        $display("test regs done");
    endtask : t_regs

    task t_gpio(input int p);
        set_pin(p, 8'h10);
        chk("gpio high", 32'h3, {30'h0, pout[p], poe[p]});
        set_pin(p, 8'he0);
        chk("gpio low", 32'h1, {30'h0, pout[p], poe[p]});
        set_pin(p, 8'h18);
        chk("gpio input", 32'h0, {31'h0, poe[p]});
        $display("test gpio %0d done", p);
    endtask : t_gpio

    task t_alt(input int p, input logic [2:0] c, input logic oe, input logic [2:0] a,
        input logic [1:0] d);
        set_pin(p, {5'h01, c});
        chk("alt oe", {31'h0, oe}, {31'h0, poe[p]});
        if (oe)
        begin
            chk("alt out high", 32'h1, {31'h0, pout[p]});
            src <= 6'h00;
            repeat (2) @(posedge clk);
            chk("alt out low", 32'h0, {31'h0, pout[p]});
            src <= 6'h3f;
        end
        chk("adc sel", {29'h0, a}, {29'h0, asel});
        chk("dac sel", {30'h0, d}, {30'h0, dsel});
        set_pin(p, 8'h08);
    endtask : t_alt

    task t_edge();
        set_pin(1, 8'h0c);
        apb(1'b1, gpc_pkg::ADDR_EDGE_CFG, 32'h3);
        pin_in <= 4'h7;
        repeat (6) @(posedge clk);
        chk("edge rise", 1, n_edge);
        apb(1'b0, gpc_pkg::ADDR_STATUS, 32'h0);
        chk("edge flag", 32'h17, rd & 32'h3f);
        apb(1'b1, gpc_pkg::ADDR_STATUS, 32'h10);
        apb(1'b0, gpc_pkg::ADDR_STATUS, 32'h0);
        chk("edge cleared", 32'h7, rd & 32'h3f);
        pin_in <= 4'h5;
        repeat (6) @(posedge clk);
        chk("edge fall", 2, n_edge);
        set_pin(1, 8'h08);
        $display("test edge done");
    endtask : t_edge

    task t_reset_cmd();
        int n;
        int k;
        n = n_rsp;
        u_host.send(1'b1);
        repeat (3) @(posedge clk);
        chk("bad key rsp", n + 1, n_rsp);
        chk("bad key detach", 32'h0, {31'h0, det});
        apb(1'b1, gpc_pkg::ADDR_NV_BASE, 32'h10);
        n = n_rsp;
        u_host.send(1'b0);
        repeat (2) @(posedge clk);
        chk("detach start", 32'h1, {31'h0, det});
        k = 0;
        while (det === 1'b1 && k < 1100)
        begin
            @(posedge clk);
            k++;
        end
        chk("detach length", gpc_pkg::DETACH_CYC, k);
        chk("no response", 0, n_rsp - n);
        chk("stored applied", 32'h3, {30'h0, pout[0], poe[0]});
        $display("test reset command done");
    endtask : t_reset_cmd

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_gpio(0);
        t_gpio(1);
        t_gpio(2);
        t_gpio(3);
        t_alt(0, 3'h1, 1'b1, 3'h0, 2'h0);
        t_alt(0, 3'h2, 1'b1, 3'h0, 2'h0);
        t_alt(0, 3'h7, 1'b0, 3'h0, 2'h0);
        t_alt(1, 3'h1, 1'b1, 3'h0, 2'h0);
        t_alt(1, 3'h2, 1'b0, 3'h1, 2'h0);
        t_alt(1, 3'h3, 1'b1, 3'h0, 2'h0);
        t_alt(1, 3'h4, 1'b0, 3'h0, 2'h0);
        t_alt(2, 3'h1, 1'b1, 3'h0, 2'h0);
        t_alt(2, 3'h2, 1'b0, 3'h2, 2'h0);
        t_alt(2, 3'h3, 1'b0, 3'h0, 2'h1);
        t_alt(3, 3'h1, 1'b1, 3'h0, 2'h0);
        t_alt(3, 3'h2, 1'b0, 3'h4, 2'h0);
        t_alt(3, 3'h3, 1'b0, 3'h0, 2'h2);
        $display("test alt functions done");
        t_edge();
        t_reset_cmd();
        final_report();
    end
endmodule : gpc_top_test
